// ### dv/afp_ctrl_model.sv
`timescale 1ns/10ps

// Modulator stand-in: toggles every PWM line each 8 cycles unless told to stop
module afp_ctrl_model (
   // Clock
   input wire logic clk_sys,
   // Stop mask from the bench, one bit per line
   input wire logic [3:0] stop,
   // PWM lines to the block
   output logic [3:0] pwm_in
);
   logic [2:0] div_q = 3'h0;

   // A stopped line keeps its level, which is the only stall the bench commands
   initial pwm_in = 4'h0;
   always @(posedge clk_sys) begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) begin
         pwm_in <= pwm_in ^ ~stop;
      end
   end
endmodule : afp_ctrl_model

// ### dv/afp_top_tb_top.sv
`timescale 1ns/10ps
`include "afp_map.svh"

module afp_top_tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic hready, hreadyout, hresp, sd_o, sd_oe, ow_o, ow_oe, sd_pin, ow_pin;
   logic hiz_ab, hiz_cd, pd_ab, pd_cd;
   logic r1_n = 1'b0;
   logic r2_n = 1'b0;
   logic [2:0] mode = 3'h0;
   logic [3:0] pwm;
   logic [3:0] stop = 4'h0;
   afp_pkg::afp_fault_s flt = '0;
   int n_mismatch = 0;
   int checks = 0;
   logic [31:0] a_st = {24'h00_0000, `AFP_ADDR_STATUS};
   logic [31:0] a_ct = {24'h00_0000, `AFP_ADDR_CONTROL};

   // Single slave, so its ready is the bus ready; flags have pull-ups
   assign hready = hreadyout;
   assign sd_pin = sd_oe ? sd_o : 1'b1;
   assign ow_pin = ow_oe ? ow_o : 1'b1;
   always #5 clk_sys = ~clk_sys;

   afp_ctrl_model i_ctrl (.clk_sys(clk_sys), .stop(stop), .pwm_in(pwm));

   afp_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_in(pwm),
      .reset_pair_one_n(r1_n), .reset_pair_two_n(r2_n), .config_select_1(mode[2]),
      .config_select_2(mode[1]), .config_select_3(mode[0]), .fault_in(flt),
      .fault_shutdown_n_o(sd_o), .fault_shutdown_n_oe(sd_oe),
      .overtemp_warning_n_o(ow_o), .overtemp_warning_n_oe(ow_oe), .hiz_ab(hiz_ab),
      .hiz_cd(hiz_cd), .pulldown_ab(pd_ab), .pulldown_cd(pd_cd));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One whole-word transfer; waits on ready, never on a cycle count
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask : ahb

   // Lets n edges pass, compares flag pins and both Hi-Z outputs once settled,
   // then returns on the next rising edge so new stimulus lands on an edge
   task automatic pins(input int n, input string nm, input logic [3:0] e);
      repeat (n) @(posedge clk_sys);
      #1;
      chk(nm, {28'h0, sd_pin, ow_pin, hiz_ab, hiz_cd}, {28'h0, e});
      @(posedge clk_sys);
   endtask : pins

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // Whole run is about 22250 cycles; a hang is cut off well beyond that
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      close_out();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      pins(2, "reset_low", 4'b1111);
      chk("pulldowns", {30'h0, pd_ab, pd_cd}, 32'h0000_0003);
      // Resets stay low long enough for the bootstrap capacitors to charge
      repeat (`AFP_BOOT_US * `AFP_CLK_MHZ) @(posedge clk_sys);
      r1_n <= 1'b1;
      r2_n <= 1'b1;
      pins(2, "idle", 4'b1100);
      chk("flag_data", {30'h0, sd_o, ow_o}, 32'h0000_0000);
      ahb(1'b0, a_ct, 32'h0000_0000);
      chk("control_reset", rd, `AFP_CT_RESET);
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      $display("test registers done");
      // Both supply monitors, each recovering on its own
      for (int i = 0; i < 2; i++) begin
         flt.uv_gate <= (i == 0);
         flt.uv_logic <= (i == 1);
         pins(2, "uv", 4'b0111);
         ahb(1'b0, a_st, 32'h0000_0000);
         chk("status_uv", rd, 32'h0000_00c8);
         flt <= '0;
         pins(2, "uv_gone", 4'b1100);
      end
      $display("test undervoltage done");
      flt.otw_cmp <= 1'b1;
      pins(2, "warn", 4'b1000);
      flt.ote_cmp <= 1'b1;
      pins(2, "ote", 4'b0011);
      flt.ote_cmp <= 1'b0;
      r1_n <= 1'b0;
      pins(2, "ote_r1", 4'b1011);
      r1_n <= 1'b1;
      pins(3, "ote_hold", 4'b0011);
      r2_n <= 1'b0;
      // Both resets now seen low: the latch lets go, C/D stays held by its reset
      pins(2, "ote_r2", 4'b1001);
      r2_n <= 1'b1;
      pins(4, "ote_clear", 4'b1000);
      flt <= '0;
      pins(2, "warn_gone", 4'b1100);
      $display("test temperature done");
      // Overload per pair; the other pair's reset shows its own Hi-Z, and its pulldown except in the single-ended pass
      for (int i = 0; i < 2; i++) begin
         flt.ovl_ab <= (i == 0);
         flt.ovl_cd <= (i == 1);
         pins(2, "ovl", (i == 0) ? 4'b0110 : 4'b0101);
         flt <= '0;
         pins(3, "ovl_held", (i == 0) ? 4'b0110 : 4'b0101);
         mode <= (i == 0) ? 3'b000 : 3'b100;
         r2_n <= (i != 0);
         r1_n <= (i == 0);
         pins(2, "ovl_reset", 4'b1111);
         chk("ovl_pd", {30'h0, pd_ab, pd_cd}, (i == 0) ? 32'h1 : 32'h0);
         // Clearing edge; the controller's one-second wait is cut short here,
         // since nothing in the block times it
         r1_n <= 1'b1;
         r2_n <= 1'b1;
         pins(3, "ovl_clear", 4'b1100);
      end
      $display("test overload done");
      stop <= 4'b0100;
      pins(970, "stall_early", 4'b1100);
      pins(60, "stall", 4'b1111);
      ahb(1'b0, a_st, 32'h0000_0000);
      chk("status_stall", rd, 32'h0000_00d0);
      stop <= 4'h0;
      pins(20, "stall_gone", 4'b1100);
      ahb(1'b1, a_ct, 32'h0000_0000);
      ahb(1'b0, a_ct, 32'h0000_0000);
      chk("control_off", rd, 32'h0000_0000);
      stop <= 4'b1000;
      pins(1100, "stall_disabled", 4'b1100);
      stop <= 4'h0;
      ahb(1'b1, a_ct, 32'h0000_0001);
      ahb(1'b0, a_ct, 32'h0000_0000);
      chk("control_on", rd, `AFP_CT_RESET);
      $display("test stall done");
      // Power-down: the controller parks both resets low to avoid pops
      r1_n <= 1'b0;
      r2_n <= 1'b0;
      pins(2, "power_down", 4'b1111);
      $display("test power-down done");
      close_out();
   end
endmodule : afp_top_tb_top

// ### logic/afp_map.svh
`ifndef AFP_MAP_SVH
`define AFP_MAP_SVH

// Register byte offsets on the AHB-Lite slave
`define AFP_ADDR_STATUS 8'h00
`define AFP_ADDR_CONTROL 8'h04

// Status register bit positions
`define AFP_ST_OTE 0
`define AFP_ST_OVL_AB 1
`define AFP_ST_OVL_CD 2
`define AFP_ST_UV 3
`define AFP_ST_STALL 4
`define AFP_ST_OTW 5
`define AFP_ST_HIZ_AB 6
`define AFP_ST_HIZ_CD 7

// Control register bit position and reset value
`define AFP_CT_STALL_EN 0
`define AFP_CT_RESET 32'h0000_0001

// Timing: stall time in microseconds, clock rate in MHz
`define AFP_STALL_US 10
`define AFP_CLK_MHZ 100
`define AFP_STALL_CYC (`AFP_STALL_US * `AFP_CLK_MHZ)
`define AFP_CNT_W 11

// Bootstrap charge time at power-up, in microseconds
`define AFP_BOOT_US 200

`endif

// ### logic/afp_pkg.sv
`include "afp_map.svh"

package afp_pkg;

   typedef logic [`AFP_CNT_W-1:0] afp_cnt_t;

   // Fault comparator and monitor inputs, active high
   typedef struct packed {
      logic otw_cmp;
      logic ote_cmp;
      logic ovl_ab;
      logic ovl_cd;
      logic uv_gate;
      logic uv_logic;
   } afp_fault_s;

   // Every flip-flop of the block
   typedef struct packed {
      logic [3:0] pwm_prev;
      afp_cnt_t [3:0] idle_cnt;
      logic [3:0] stalled;
      logic overtemp_error;
      logic ovl_ab;
      logic ovl_cd;
      logic uv;
      logic seen_one;
      logic seen_two;
      logic r1_prev;
      logic r2_prev;
      logic sd_o;
      logic sd_oe;
      logic otw_o;
      logic otw_oe;
      logic hiz_ab;
      logic hiz_cd;
      logic pd_ab;
      logic pd_cd;
      logic stall_en;
      logic bus_wr;
      logic [7:0] bus_addr;
      logic [31:0] rdata;
      logic readyout;
      logic resp;
   } afp_state_s;

endpackage : afp_pkg

// ### logic/afp_top.sv
// Behaviour
// - Shutdown and warning flags are open-drain active-low
// - Any shutdown fault pulls shutdown flag low
// - Warning flag follows the temperature warning comparator
// - Flag pair encodes error, fault or warning
// - No faults leaves both flags released
// - Either reset low forces shutdown flag high
// - Fault sets outputs Hi-Z, flag low
// - Undervoltage recovers automatically when supply returns
// - PWM input stuck over 10us sets Hi-Z
// - Stalled PWM does not assert shutdown flag
// - Reset low enables pulldowns except single-ended
// - Operational while supply monitors report good
// - Overtemperature error latched until both resets asserted
// - Reset rising edge clears overload latch
// - Each reset forces its bridge pair Hi-Z
// - Overload shuts down only its own pair
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "afp_map.svh"

module afp_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Controller pins
   input wire logic [3:0] pwm_in,
   input wire logic reset_pair_one_n,
   input wire logic reset_pair_two_n,
   input wire logic config_select_1,
   input wire logic config_select_2,
   input wire logic config_select_3,
   // Fault monitors
   input wire afp_pkg::afp_fault_s fault_in,
   // Open-drain flags
   output logic fault_shutdown_n_o,
   output logic fault_shutdown_n_oe,
   output logic overtemp_warning_n_o,
   output logic overtemp_warning_n_oe,
   // Power stage control
   output logic hiz_ab,
   output logic hiz_cd,
   output logic pulldown_ab,
   output logic pulldown_cd
);

   afp_pkg::afp_state_s q;
   afp_pkg::afp_state_s d;
   logic rose_one;
   logic rose_two;
   logic single_ended;
   logic stall_any;
   logic addr_phase;
   logic [31:0] status_word;
   logic [31:0] control_word;

   // Rising edge of a sampled level
   function automatic logic rising(input logic prev, input logic cur);
      rising = cur & ~prev;
   endfunction : rising

   // Reset-pin edges and mode decode
   assign rose_one = rising(q.r1_prev, reset_pair_one_n);
   assign rose_two = rising(q.r2_prev, reset_pair_two_n);
   assign single_ended = config_select_1 & ~config_select_2 & ~config_select_3;
   assign stall_any = |q.stalled;
   assign addr_phase = hsel & htrans[1] & hready;

   // Readback words; write data in flight is forwarded so a read right
   // after a write sees the new control value
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`AFP_ST_OTE] = q.overtemp_error;
      status_word[`AFP_ST_OVL_AB] = q.ovl_ab;
      status_word[`AFP_ST_OVL_CD] = q.ovl_cd;
      status_word[`AFP_ST_UV] = q.uv;
      status_word[`AFP_ST_STALL] = stall_any;
      status_word[`AFP_ST_OTW] = q.otw_oe;
      status_word[`AFP_ST_HIZ_AB] = q.hiz_ab;
      status_word[`AFP_ST_HIZ_CD] = q.hiz_cd;
      control_word = 32'h0000_0000;
      if (q.bus_wr && q.bus_addr == `AFP_ADDR_CONTROL) begin
         control_word[`AFP_CT_STALL_EN] = hwdata[`AFP_CT_STALL_EN];
      end else begin
         control_word[`AFP_CT_STALL_EN] = q.stall_en;
      end
   end

   // Next-state logic for the whole block
   always_comb begin
      d = q;
      d.r1_prev = reset_pair_one_n;
      d.r2_prev = reset_pair_two_n;
      d.pwm_prev = pwm_in;

      // Activity detector: each input has its own idle timer
      for (int i = 0; i < 4; i++) begin
         if (pwm_in[i] != q.pwm_prev[i]) begin
            d.idle_cnt[i] = '0;
            d.stalled[i] = 1'b0;
         end else if (q.idle_cnt[i] != afp_pkg::afp_cnt_t'(`AFP_STALL_CYC)) begin
            d.idle_cnt[i] = q.idle_cnt[i] + afp_pkg::afp_cnt_t'(1);
         end else begin
            d.stalled[i] = q.stall_en;
         end
      end

      // Supply monitors recover on their own
      d.uv = fault_in.uv_gate | fault_in.uv_logic;

      // Overload latches per pair; a new overload beats the clearing edge
      d.ovl_ab = fault_in.ovl_ab | (q.ovl_ab & ~(rose_one | rose_two));
      d.ovl_cd = fault_in.ovl_cd | (q.ovl_cd & ~(rose_one | rose_two));

      // Overtemperature latch clears once both resets were seen low
      d.seen_one = q.overtemp_error & (q.seen_one | ~reset_pair_one_n);
      d.seen_two = q.overtemp_error & (q.seen_two | ~reset_pair_two_n);
      if (q.seen_one && q.seen_two) begin
         d.overtemp_error = fault_in.ote_cmp;
         d.seen_one = 1'b0;
         d.seen_two = 1'b0;
      end else begin
         d.overtemp_error = q.overtemp_error | fault_in.ote_cmp;
      end

      // Flags: low level only, released by the pullup
      d.sd_o = 1'b0;
      d.otw_o = 1'b0;
      d.sd_oe = (d.overtemp_error | d.ovl_ab | d.ovl_cd | d.uv)
         & reset_pair_one_n & reset_pair_two_n;
      d.otw_oe = fault_in.otw_cmp;

      // Power stage: stall stops all four half-bridges
      d.hiz_ab = ~reset_pair_one_n | d.overtemp_error | d.uv | d.ovl_ab | (|d.stalled);
      d.hiz_cd = ~reset_pair_two_n | d.overtemp_error | d.uv | d.ovl_cd | (|d.stalled);

      // Bootstrap pulldowns not used in single-ended mode
      d.pd_ab = ~reset_pair_one_n & ~single_ended;
      d.pd_cd = ~reset_pair_two_n & ~single_ended;

      // Bus slave: zero wait states, always OKAY
      d.readyout = 1'b1;
      d.resp = 1'b0;
      if (q.bus_wr && q.bus_addr == `AFP_ADDR_CONTROL) begin
         d.stall_en = hwdata[`AFP_CT_STALL_EN];
      end
      d.bus_wr = addr_phase & hwrite;
      if (addr_phase) begin
         d.bus_addr = haddr[7:0];
      end
      d.rdata = 32'h0000_0000;
      if (addr_phase && !hwrite && haddr[31:8] == 24'h00_0000) begin
         unique case (haddr[7:0])
            `AFP_ADDR_STATUS: d.rdata = status_word;
            `AFP_ADDR_CONTROL: d.rdata = control_word;
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register; power-on state is safe: outputs Hi-Z, flags released
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.r1_prev <= 1'b1;
         q.r2_prev <= 1'b1;
         q.hiz_ab <= 1'b1;
         q.hiz_cd <= 1'b1;
         q.stall_en <= 1'(`AFP_CT_RESET); // Only the enable bit is stored
         q.readyout <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   assign hrdata = q.rdata;
   assign hreadyout = q.readyout;
   assign hresp = q.resp;
   assign fault_shutdown_n_o = q.sd_o;
   assign fault_shutdown_n_oe = q.sd_oe;
   assign overtemp_warning_n_o = q.otw_o;
   assign overtemp_warning_n_oe = q.otw_oe;
   assign hiz_ab = q.hiz_ab;
   assign hiz_cd = q.hiz_cd;
   assign pulldown_ab = q.pd_ab;
   assign pulldown_cd = q.pd_cd;

   default clocking afp_cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   // Flags never drive high
   property p_open_drain;
      (fault_shutdown_n_o == 1'b0) && (overtemp_warning_n_o == 1'b0);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("flag drives a high level");

   // Either reset low releases the shutdown flag next cycle
   property p_reset_forces_high;
      (!reset_pair_one_n || !reset_pair_two_n) |=> !fault_shutdown_n_oe;
   endproperty
   a_reset_forces_high: assert property (p_reset_forces_high)
      else $error("shutdown flag low while a reset is held");

   // Warning flag tracks its comparator one cycle later
   property p_warning_follows;
      fault_in.otw_cmp |=> overtemp_warning_n_oe ##0 $past(fault_in.otw_cmp);
   endproperty
   a_warning_follows: assert property (p_warning_follows)
      else $error("warning flag not pulled with comparator high");

   // Undervoltage with resets high: flag low and both pairs Hi-Z
   property p_uv_shutdown;
      (fault_in.uv_gate && reset_pair_one_n && reset_pair_two_n)
         |=> fault_shutdown_n_oe && hiz_ab && hiz_cd;
   endproperty
   a_uv_shutdown: assert property (p_uv_shutdown)
      else $error("undervoltage did not shut down");

   // Clean inputs and no latched fault: both flags released next cycle
   property p_normal;
      (!fault_in.uv_gate && !fault_in.uv_logic && !fault_in.otw_cmp && !q.overtemp_error
         && !fault_in.ote_cmp && !q.ovl_ab && !q.ovl_cd && !fault_in.ovl_ab
         && !fault_in.ovl_cd) |=> !fault_shutdown_n_oe && !overtemp_warning_n_oe;
   endproperty
   a_normal: assert property (p_normal)
      else $error("flag asserted in normal operation");

   // A PWM line held still through the whole stall time stops the stage;
   // line 2 is the one the tests freeze with detection enabled
   property p_stall_hiz;
      (q.stall_en && $stable(pwm_in[2])
         && q.idle_cnt[2] == afp_pkg::afp_cnt_t'(`AFP_STALL_CYC))
         |=> hiz_ab && hiz_cd;
   endproperty
   a_stall_hiz: assert property (p_stall_hiz)
      else $error("stalled PWM did not set Hi-Z");

   // A stall alone never pulls the shutdown flag
   property p_stall_no_flag;
      (stall_any && !q.overtemp_error && !q.ovl_ab && !q.ovl_cd && !q.uv) |-> !fault_shutdown_n_oe;
   endproperty
   a_stall_no_flag: assert property (p_stall_no_flag)
      else $error("shutdown flag low for stalled PWM");

   // Overtemperature latch holds while neither reset has been seen low
   property p_ote_latched;
      (q.overtemp_error && !q.seen_one && !q.seen_two && reset_pair_one_n && reset_pair_two_n)
         |=> q.overtemp_error && hiz_ab && hiz_cd;
   endproperty
   a_ote_latched: assert property (p_ote_latched)
      else $error("overtemperature latch lost without reset");

   // Reset rising edge with no overload present clears both latches
   property p_ovl_clear;
      (rose_one && !fault_in.ovl_ab && !fault_in.ovl_cd) |=> !q.ovl_ab && !q.ovl_cd;
   endproperty
   a_ovl_clear: assert property (p_ovl_clear)
      else $error("overload latch not cleared by reset edge");

   // Overload on one pair leaves the other pair switching
   property p_ovl_independent;
      (q.ovl_ab && !q.ovl_cd && !q.overtemp_error && !q.uv && !stall_any && reset_pair_two_n
         && !fault_in.ovl_cd && !fault_in.ote_cmp && !fault_in.uv_gate
         && !fault_in.uv_logic && !(|d.stalled) && !rose_one && !rose_two)
         |=> hiz_ab && !hiz_cd;
   endproperty
   a_ovl_independent: assert property (p_ovl_independent)
      else $error("overload spread to the other pair");

   // Pulldowns stay off in single-ended mode, reset or not
   property p_pulldown;
      single_ended |=> !pulldown_ab && !pulldown_cd;
   endproperty
   a_pulldown: assert property (p_pulldown)
      else $error("pulldown enabled in single-ended mode");

   // Holding the first reset low stops half-bridges A and B
   property p_reset_hiz_ab;
      !reset_pair_one_n |=> hiz_ab;
   endproperty
   a_reset_hiz_ab: assert property (p_reset_hiz_ab)
      else $error("pair A/B switching while its reset is held");

   // Holding the second reset low stops half-bridges C and D
   property p_reset_hiz_cd;
      !reset_pair_two_n |=> hiz_cd;
   endproperty
   a_reset_hiz_cd: assert property (p_reset_hiz_cd)
      else $error("pair C/D switching while its reset is held");

   // Warning flag lets go as soon as the comparator drops
   property p_warning_release;
      !fault_in.otw_cmp |=> !overtemp_warning_n_oe;
   endproperty
   a_warning_release: assert property (p_warning_release)
      else $error("warning flag held with comparator low");

   // Supply fault clears by itself once both monitors are good again
   property p_uv_recover;
      (!fault_in.uv_gate && !fault_in.uv_logic) |=> !q.uv;
   endproperty
   a_uv_recover: assert property (p_uv_recover)
      else $error("undervoltage state kept after supplies recovered");

   // An edge on a PWM line restarts its stall timer and clears its stall
   property p_stall_restart;
      (pwm_in[2] != q.pwm_prev[2])
         |=> (q.idle_cnt[2] == afp_pkg::afp_cnt_t'(0)) && !q.stalled[2];
   endproperty
   a_stall_restart: assert property (p_stall_restart)
      else $error("stall timer not restarted by a PWM edge");

   // Latched overtemperature keeps the shutdown flag low until both resets were seen
   property p_ote_flag;
      (q.overtemp_error && !(q.seen_one && q.seen_two) && reset_pair_one_n && reset_pair_two_n)
         |=> fault_shutdown_n_oe;
   endproperty
   a_ote_flag: assert property (p_ote_flag)
      else $error("shutdown flag released with overtemperature latched");

   // A new overload with both resets high pulls the shutdown flag
   property p_ovl_flag;
      ((fault_in.ovl_ab || fault_in.ovl_cd) && reset_pair_one_n && reset_pair_two_n)
         |=> fault_shutdown_n_oe;
   endproperty
   a_ovl_flag: assert property (p_ovl_flag)
      else $error("overload did not pull the shutdown flag");

endmodule : afp_top
